/* File: logic/sps_pkg.sv */
// Shared constants, classes and carrier types of the servo parameter store.
package sps_pkg;

    // ********************************************************************
    // Widths and sizes
    // ********************************************************************
    localparam int NUM_W      = 10;
    localparam int DATA_W     = 32;
    localparam int MON_COUNT  = 100;
    localparam int TBL_COUNT  = 100;
    localparam int TBL_W      = 7;
    localparam int SLOT_COUNT = 700;
    localparam int OPT_W      = 3;

    // ********************************************************************
    // Parameter number ranges
    // ********************************************************************
    localparam logic [NUM_W-1:0] GEN_LAST   = 10'h0C7;
    localparam logic [NUM_W-1:0] MECH_FIRST = 10'h0C8;
    localparam logic [NUM_W-1:0] MECH_LAST  = 10'h12B;
    localparam logic [NUM_W-1:0] MON_FIRST  = 10'h12C;
    localparam logic [NUM_W-1:0] MON_LAST   = 10'h18F;
    localparam logic [NUM_W-1:0] REG_FIRST  = 10'h190;
    localparam logic [NUM_W-1:0] REG_LAST   = 10'h1C1;
    localparam logic [NUM_W-1:0] VOL_FIRST  = 10'h1F4;
    localparam logic [NUM_W-1:0] VOL_LAST   = 10'h225;
    localparam logic [NUM_W-1:0] PVAL_FIRST = 10'h258;
    localparam logic [NUM_W-1:0] PVAL_LAST  = 10'h2BB;
    localparam logic [NUM_W-1:0] POPT_FIRST = 10'h2BC;
    localparam logic [NUM_W-1:0] POPT_LAST  = 10'h31F;

    // ********************************************************************
    // Storage slot layout
    // ********************************************************************
    localparam logic [NUM_W-1:0] SLOT_MECH  = 10'h0C8;
    localparam logic [NUM_W-1:0] SLOT_REG   = 10'h12C;
    localparam logic [NUM_W-1:0] SLOT_VOL   = 10'h15E;
    localparam logic [NUM_W-1:0] SLOT_PVAL  = 10'h190;
    localparam logic [NUM_W-1:0] SLOT_POPT  = 10'h1F4;
    localparam logic [NUM_W-1:0] SLOT_PEND  = 10'h258;
    localparam logic [NUM_W-1:0] PEND_SHIFT = 10'h190;
    localparam int               MECH_COUNT = 100;
    localparam int               VOL_COUNT  = 50;

    // ********************************************************************
    // Value limits and reset value
    // ********************************************************************
    localparam logic signed [DATA_W-1:0] WIDE_MIN   = 32'shC4653601;
    localparam logic signed [DATA_W-1:0] NARROW_MIN = 32'shFA0A1F01;
    localparam logic signed [DATA_W-1:0] USER_MAX   = 32'sh05F5E0FF;
    localparam logic signed [DATA_W-1:0] OPT_MIN    = 32'sh00000000;
    localparam logic signed [DATA_W-1:0] OPT_MAX    = 32'sh00000007;
    localparam logic signed [DATA_W-1:0] RESET_VAL  = 32'sh00000000;

    // ********************************************************************
    // Move option fields
    // ********************************************************************
    localparam int             OPT_ABS_BIT = 2;
    localparam logic [1:0]     DIR_NEAREST = 2'h0;
    localparam logic [1:0]     DIR_NOHOME  = 2'h1;
    localparam logic [1:0]     DIR_MULTI   = 2'h2;
    localparam logic [1:0]     DIR_RSVD    = 2'h3;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [7:0] {
        CLS_NONE = 8'h01,
        CLS_GEN  = 8'h02,
        CLS_MECH = 8'h04,
        CLS_MON  = 8'h08,
        CLS_REG  = 8'h10,
        CLS_VOL  = 8'h20,
        CLS_PVAL = 8'h40,
        CLS_POPT = 8'h80
    } sps_class_type;

    typedef struct packed {
        logic                     write;
        logic [NUM_W-1:0]         num;
        logic signed [DATA_W-1:0] data;
    } sps_req_type;

    typedef struct packed {
        logic                     done;
        logic                     ok;
        logic signed [DATA_W-1:0] rdata;
    } sps_resp_type;

    typedef struct packed {
        logic                     done;
        logic                     error;
        logic                     reserved;
        logic signed [DATA_W-1:0] target;
        logic                     absolute;
        logic [1:0]               dirType;
        logic                     nearest;
        logic                     noHomeCross;
        logic                     multiTurn;
    } sps_tbl_type;

endpackage

/* File: logic/sps_class_decode.sv */
// Parameter number class decoder with slot mapping and value range check.
module sps_class_decode
    import sps_pkg::*;
(
    // Request fields
    input  wire logic [NUM_W-1:0]         paramNum,
    input  wire logic signed [DATA_W-1:0] value,
    // Decoded result
    output sps_class_type                 paramClass,
    output logic [NUM_W-1:0]              slotIdx,
    output logic                          valueOk
);

    always_comb begin
        paramClass = CLS_NONE;
        slotIdx    = 10'h000;
        valueOk    = 1'b0;
        if (paramNum <= GEN_LAST) begin
            paramClass = CLS_GEN;
            slotIdx    = paramNum;
            valueOk    = 1'b1;
        end else if (paramNum <= MECH_LAST) begin
            paramClass = CLS_MECH;
            slotIdx    = SLOT_MECH + (paramNum - MECH_FIRST);
            valueOk    = 1'b1;
        end else if (paramNum <= MON_LAST) begin
            paramClass = CLS_MON;
            slotIdx    = paramNum - MON_FIRST;
        end else if (paramNum >= REG_FIRST && paramNum <= REG_LAST) begin
            paramClass = CLS_REG;
            slotIdx    = SLOT_REG + (paramNum - REG_FIRST);
            valueOk    = (value >= WIDE_MIN) && (value <= USER_MAX);
        end else if (paramNum >= VOL_FIRST && paramNum <= VOL_LAST) begin
            paramClass = CLS_VOL;
            slotIdx    = SLOT_VOL + (paramNum - VOL_FIRST);
            valueOk    = (value >= NARROW_MIN) && (value <= USER_MAX);
        end else if (paramNum >= PVAL_FIRST && paramNum <= PVAL_LAST) begin
            paramClass = CLS_PVAL;
            slotIdx    = SLOT_PVAL + (paramNum - PVAL_FIRST);
            valueOk    = (value >= WIDE_MIN) && (value <= USER_MAX);
        end else if (paramNum >= POPT_FIRST && paramNum <= POPT_LAST) begin
            paramClass = CLS_POPT;
            slotIdx    = SLOT_POPT + (paramNum - POPT_FIRST);
            valueOk    = (value >= OPT_MIN) && (value <= OPT_MAX);
        end
    end

endmodule

/* File: logic/sps_store.sv */
// Numbered parameter and monitor store with point set table fetch.

module sps_store
    import sps_pkg::*;
(
    // Clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             srst,
    // Mode strap pin
    input  wire logic                             mechModeStrap,
    output logic                                  mechModeActive,
    // Parameter access
    input  wire logic                             reqValid,
    input  sps_req_type                           req,
    output sps_resp_type                          resp,
    // Monitor values from the drive
    input  wire logic [MON_COUNT-1:0][DATA_W-1:0] monValues,
    // Table reference fetch
    input  wire logic                             tblReq,
    input  wire logic [TBL_W-1:0]                 tblEntry,
    output sps_tbl_type                           tbl
);

    // ********************************************************************
    // Mode strap capture
    // ********************************************************************
    logic strapMeta_reg, strapMeta_next;
    logic strapSync_reg, strapSync_next;
    logic captured_reg,  captured_next;
    logic mode_reg,      mode_next;

    // The strap is sampled through reset so the sync chain already holds
    // the pin level on the first cycle after release.
    always_comb begin
        strapMeta_next = mechModeStrap;
        strapSync_next = strapMeta_reg;
        captured_next  = captured_reg;
        mode_next      = mode_reg;
        if (!captured_reg) begin
            mode_next     = strapSync_reg;
            captured_next = 1'b1;
        end
        if (srst) begin
            captured_next = 1'b0;
            mode_next     = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        strapMeta_reg <= strapMeta_next;
        strapSync_reg <= strapSync_next;
        captured_reg  <= captured_next;
        mode_reg      <= mode_next;
    end

    assign mechModeActive = mode_reg;

    // ********************************************************************
    // Access decode
    // ********************************************************************
    sps_class_type    paramClass;
    logic [NUM_W-1:0] slotIdx;
    logic             valueOk;
    logic             wrAllowed;
    logic             accTake;

    sps_class_decode u_decode (
        .paramNum   (req.num),
        .value      (req.data),
        .paramClass (paramClass),
        .slotIdx    (slotIdx),
        .valueOk    (valueOk)
    );

    always_comb begin
        case (paramClass)
            CLS_GEN, CLS_REG, CLS_VOL, CLS_PVAL, CLS_POPT: wrAllowed = valueOk;
            CLS_MECH: wrAllowed = valueOk && mode_reg;
            default:  wrAllowed = 1'b0;
        endcase
    end

    assign accTake = reqValid && !srst;

    // ********************************************************************
    // Storage
    // ********************************************************************
    logic signed [DATA_W-1:0] store_reg  [SLOT_COUNT];
    logic signed [DATA_W-1:0] store_next [SLOT_COUNT];

    // Stored classes have no reset so that their contents survive; only
    // the volatile block and the live mechanical copy are touched by srst.
    always_comb begin
        store_next = store_reg;
        if (accTake && req.write && wrAllowed) begin
            // mechanical writes land in the pending copy
            if (paramClass == CLS_MECH) begin
                store_next[slotIdx + PEND_SHIFT] = req.data;
            end else begin
                store_next[slotIdx] = req.data;
            end
        end
        if (srst) begin
            for (int i = 0; i < VOL_COUNT; i++) begin
                store_next[int'(SLOT_VOL) + i] = RESET_VAL;
            end
            for (int i = 0; i < MECH_COUNT; i++) begin
                store_next[int'(SLOT_MECH) + i] = store_reg[int'(SLOT_PEND) + i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        store_reg <= store_next;
    end

    // ********************************************************************
    // Access answer
    // ********************************************************************
    sps_resp_type resp_reg, resp_next;

    always_comb begin
        resp_next = '0;
        // answer one cycle after the request
        if (accTake) begin
            resp_next.done = 1'b1;
            if (req.write) begin
                resp_next.ok = wrAllowed;
            end else if (paramClass == CLS_MON) begin
                resp_next.ok    = 1'b1;
                resp_next.rdata = monValues[slotIdx[6:0]];
            end else if (paramClass != CLS_NONE) begin
                resp_next.ok    = 1'b1;
                resp_next.rdata = store_reg[slotIdx];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        resp_reg <= resp_next;
    end

    assign resp = resp_reg;

    // ********************************************************************
    // Table reference fetch
    // ********************************************************************
    sps_tbl_type      tbl_reg, tbl_next;
    logic [NUM_W-1:0] tblWide;
    logic [OPT_W-1:0] optCode;

    assign tblWide = {3'h0, tblEntry};
    assign optCode = store_reg[SLOT_POPT + tblWide][OPT_W-1:0];

    always_comb begin
        tbl_next = '0;
        if (tblReq && !srst) begin
            tbl_next.done = 1'b1;
            if (tblWide >= NUM_W'(TBL_COUNT)) begin
                tbl_next.error = 1'b1;
            end else begin
                tbl_next.target      = store_reg[SLOT_PVAL + tblWide];
                tbl_next.absolute    = optCode[OPT_ABS_BIT];
                tbl_next.dirType     = optCode[1:0];
                tbl_next.reserved    = (optCode[1:0] == DIR_RSVD);
                tbl_next.nearest     = (optCode[1:0] == DIR_NEAREST);
                tbl_next.noHomeCross = (optCode[1:0] == DIR_NOHOME);
                tbl_next.multiTurn   = (optCode[1:0] == DIR_MULTI);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        tbl_reg <= tbl_next;
    end

    assign tbl = tbl_reg;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_wrReq;
        accTake && req.write;
    endsequence

    sequence s_rejected;
        ##1 (resp.done && !resp.ok);
    endsequence

    chk_gen_write: assert property (
        s_wrReq and (paramClass == CLS_GEN) |=> resp.done && resp.ok)
        else $error("general write not accepted");
    chk_mech_gate: assert property (
        s_wrReq and (paramClass == CLS_MECH) && !mode_reg |-> s_rejected)
        else $error("mechanical write accepted outside setting mode");
    // A live slot may never have been written, so case equality keeps it comparable.
    chk_mech_stale: assert property (
        s_wrReq and (paramClass == CLS_MECH) |=>
        store_reg[$past(slotIdx)] === $past(store_reg[slotIdx]))
        else $error("mechanical live value changed before power cycle");
    chk_mon_reject: assert property (
        s_wrReq and (paramClass == CLS_MON) |-> s_rejected)
        else $error("monitor write accepted");
    chk_reg_range: assert property (
        s_wrReq and (paramClass == CLS_REG) && (req.data < WIDE_MIN) |-> s_rejected)
        else $error("registration value below limit accepted");
    chk_vol_clear: assert property (
        disable iff (1'b0) srst |=> store_reg[SLOT_VOL] == RESET_VAL)
        else $error("volatile entry not cleared at power-on");
    chk_read_value: assert property (
        accTake && !req.write && (paramClass == CLS_GEN) |=>
        resp.ok && resp.rdata == $past(store_reg[slotIdx]))
        else $error("read returned wrong value");
    chk_tbl_target: assert property (
        tblReq && (tblWide < NUM_W'(TBL_COUNT)) |=>
        tbl.done && tbl.target == $past(store_reg[SLOT_PVAL + tblWide]))
        else $error("table target fetched from wrong entry");
    chk_opt_range: assert property (
        s_wrReq and (paramClass == CLS_POPT) && (req.data > OPT_MAX) |-> s_rejected)
        else $error("option above seven accepted");
    chk_opt_decode: assert property (
        tbl.done && !tbl.error |-> tbl.reserved == (tbl.dirType == DIR_RSVD))
        else $error("reserved option not flagged");
    chk_dir_type: assert property (
        tbl.done && !tbl.error && tbl.dirType == DIR_MULTI |->
        tbl.multiTurn && !tbl.nearest && !tbl.noHomeCross)
        else $error("multi-turn type decoded wrongly");
    chk_mode_hold: assert property (
        captured_reg |=> $stable(mode_reg))
        else $error("operating mode changed after power-on");
    chk_undef_reject: assert property (
        accTake and (paramClass == CLS_NONE) |=> resp.done && !resp.ok && resp.rdata == 0)
        else $error("undefined number accepted");

endmodule

/* File: sim/sps_host_model.sv */
// Host program model that issues parameter reads and writes to the store.
module sps_host_model
    import sps_pkg::*;
(
    // Clock
    input  wire logic clk_sys,
    // Parameter access
    output logic         reqValid,
    output sps_req_type  req,
    input  sps_resp_type resp
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reqValid = 1'b0;
        req      = '0;
    end

    // ********************************************************************
    // One access
    // ********************************************************************
    task automatic access(input logic wr, input logic [NUM_W-1:0] num,
                          input logic signed [DATA_W-1:0] data, output sps_resp_type rsp);
        @(posedge clk_sys);
        #1;
        reqValid = 1'b1;
        req      = '{wr, num, data};
        @(posedge clk_sys);
        #1;
        reqValid = 1'b0;
        // Released lines carry junk, so a store that samples late is caught.
        req      = ~req;
        rsp      = resp;
    endtask
endmodule

/* File: sim/sps_store_tb.sv */
// Self-checking testbench of the servo parameter store.
`define CHK(got, exp, msg) begin nTests++; if ((got) !== (exp)) begin badCount++; \
    $display("mismatch at %0t: %s", $time, msg); end end

module sps_store_tb
    import sps_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************************************************
    // Signals and instances
    // ********************************************************************
    logic                             clk_sys;
    logic                             srst;
    logic                             mechModeStrap;
    logic                             mechModeActive;
    logic                             reqValid;
    sps_req_type                      req;
    sps_resp_type                     resp;
    logic [MON_COUNT-1:0][DATA_W-1:0] monValues;
    logic                             tblReq;
    logic [TBL_W-1:0]                 tblEntry;
    sps_tbl_type                      tbl;
    int                               nTests;
    int                               badCount;

    sps_store dut (.clk_sys(clk_sys), .srst(srst), .mechModeStrap(mechModeStrap),
        .mechModeActive(mechModeActive), .reqValid(reqValid), .req(req), .resp(resp),
        .monValues(monValues), .tblReq(tblReq), .tblEntry(tblEntry), .tbl(tbl));

    sps_host_model host (.clk_sys(clk_sys), .reqValid(reqValid), .req(req), .resp(resp));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic summarize();
        $display("checks %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The strap is set together with srst so the synchroniser holds it at release.
    task automatic powerCycle(input logic strap);
        @(posedge clk_sys);
        #1;
        mechModeStrap = strap;
        srst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        mechModeStrap = ~strap;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(mechModeActive, strap, "mode not latched")
    endtask

    task automatic wr(input logic [NUM_W-1:0] n, input logic signed [DATA_W-1:0] d,
                      input logic expOk);
        sps_resp_type r;
        host.access(1'b1, n, d, r);
        `CHK(r.done, 1'b1, "write not answered")
        `CHK(r.ok, expOk, "write accept flag")
    endtask

    task automatic rd(input logic [NUM_W-1:0] n, input logic expOk,
                      input logic signed [DATA_W-1:0] expData);
        sps_resp_type r;
        host.access(1'b0, n, 32'h00000000, r);
        `CHK(r.done, 1'b1, "read not answered")
        `CHK(r.ok, expOk, "read accept flag")
        `CHK(r.rdata, (expOk ? expData : RESET_VAL), "read data")
    endtask

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic tGeneral();
        wr(10'h000, 32'h7FFFFFFF, 1'b1);
        wr(GEN_LAST, 32'h80000000, 1'b1);
        rd(10'h000, 1'b1, 32'h7FFFFFFF);
        rd(GEN_LAST, 1'b1, 32'h80000000);
    endtask

    task automatic tMech();
        powerCycle(1'b1);
        wr(MECH_FIRST, 32'h0000AAAA, 1'b1);
        wr(MECH_LAST, 32'hFFFF5555, 1'b1);
        powerCycle(1'b1);
        rd(MECH_FIRST, 1'b1, 32'h0000AAAA);
        rd(MECH_LAST, 1'b1, 32'hFFFF5555);
        wr(MECH_FIRST, 32'h00001234, 1'b1);
        rd(MECH_FIRST, 1'b1, 32'h0000AAAA);
        powerCycle(1'b0);
        rd(MECH_FIRST, 1'b1, 32'h00001234);
        wr(MECH_FIRST, 32'h00009999, 1'b0);
        powerCycle(1'b0);
        rd(MECH_FIRST, 1'b1, 32'h00001234);
    endtask

    task automatic tMonitor();
        rd(MON_FIRST, 1'b1, monValues[0]);
        rd(MON_LAST, 1'b1, monValues[MON_COUNT-1]);
        wr(MON_FIRST, 32'h00000001, 1'b0);
        wr(MON_LAST, 32'h00000001, 1'b0);
        rd(MON_FIRST, 1'b1, monValues[0]);
    endtask

    // Each range-checked class (registration, volatile, point value, point option) is probed at both limits and one step outside them.
    task automatic tLimits();
        logic [NUM_W-1:0]         f[4] = '{REG_FIRST, VOL_FIRST, PVAL_FIRST, POPT_FIRST};
        logic [NUM_W-1:0]         l[4] = '{REG_LAST, VOL_LAST, PVAL_LAST, POPT_LAST};
        logic signed [DATA_W-1:0] mn[4] = '{WIDE_MIN, NARROW_MIN, WIDE_MIN, OPT_MIN};
        logic signed [DATA_W-1:0] mx[4] = '{USER_MAX, USER_MAX, USER_MAX, OPT_MAX};
        for (int k = 0; k < 4; k++) begin
            wr(f[k], mn[k], 1'b1);
            wr(f[k], mn[k] - 32'sh00000001, 1'b0);
            rd(f[k], 1'b1, mn[k]);
            wr(l[k], mx[k], 1'b1);
            wr(l[k], mx[k] + 32'sh00000001, 1'b0);
            rd(l[k], 1'b1, mx[k]);
        end
    endtask

    task automatic tVolatile();
        wr(REG_FIRST, 32'h00C0FFEE, 1'b1);
        wr(VOL_FIRST + 10'h001, 32'h01234567, 1'b1);
        powerCycle(1'b0);
        rd(VOL_FIRST + 10'h001, 1'b1, RESET_VAL);
        rd(REG_FIRST, 1'b1, 32'h00C0FFEE);
    endtask

    task automatic tUndefined();
        logic [NUM_W-1:0] u[6] = '{10'h1C2, 10'h1F3, 10'h226, 10'h257, 10'h320, 10'h3FF};
        for (int k = 0; k < 6; k++) begin
            wr(u[k], 32'h00000000, 1'b0);
            rd(u[k], 1'b0, RESET_VAL);
        end
    endtask

    // Every option code is fetched, including both reserved ones.
    task automatic tTable();
        sps_tbl_type t;
        logic [2:0]  c;
        for (int n = 0; n <= 8; n++) begin
            c = 3'(n);
            if (n < 8) begin
                wr(PVAL_FIRST + 10'(n), 32'h00010000 + 32'(n), 1'b1);
                wr(POPT_FIRST + 10'(n), 32'(n), 1'b1);
            end
            @(posedge clk_sys);
            #1;
            tblReq = 1'b1;
            tblEntry = (n < 8) ? 7'(n) : 7'h64;
            @(posedge clk_sys);
            #1;
            tblReq = 1'b0;
            tblEntry = ~tblEntry;
            t = tbl;
            `CHK(t.done, 1'b1, "fetch not answered")
            `CHK(t.error, (n == 8), "fetch error flag")
            if (n < 8) begin
                `CHK(t.target, 32'h00010000 + 32'(n), "fetched target")
                `CHK(t.reserved, (c[1:0] == 2'h3), "reserved code")
                `CHK(t.absolute, c[2], "absolute move")
                `CHK(t.dirType, c[1:0], "direction type")
                `CHK(t.nearest, (c[1:0] == DIR_NEAREST), "nearest flag")
                `CHK(t.noHomeCross, (c[1:0] == DIR_NOHOME), "home flag")
                `CHK(t.multiTurn, (c[1:0] == DIR_MULTI), "multi turn flag")
            end else begin
                `CHK(t.target, RESET_VAL, "target on error")
            end
        end
    endtask

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial begin
        nTests = 0;
        badCount = 0;
        srst = 1'b1;
        mechModeStrap = 1'b0;
        tblReq = 1'b0;
        tblEntry = '0;
        for (int k = 0; k < MON_COUNT; k++) begin
            monValues[k] = 32'hA5000000 + 32'(k);
        end
        powerCycle(1'b0);
        tGeneral();
        tMech();
        tMonitor();
        tLimits();
        tVolatile();
        tUndefined();
        tTable();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        summarize();
    end
endmodule
